// ### pkg/sysctl_pkg.sv
// Package: register map, reset values, opcodes, timing and shared types
package sysctl_pkg;
  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_PRIO = 8'hf9;
  localparam logic [7:0] IDX_PEND = 8'hfa;
  localparam logic [7:0] IDX_MASK = 8'hfb;
  localparam logic [7:0] IDX_STAT = 8'hf0;
  // Field positions
  localparam int MASK_GLOBAL_BIT = 7;
  localparam int NUM_REQ = 6;
  // Values after reset
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [5:0] PEND_RST = 6'h00;
  localparam logic [2:0] PRIO_RST = 3'h0;
  // Opcodes seen on the execute strobe
  localparam logic [7:0] OP_WDOG_REFRESH = 8'h5f;
  localparam logic [7:0] OP_WDOG_HALT_RUN = 8'h4f;
  // Fetch address after reset or stop release
  localparam logic [15:0] RESTART_PC = 16'h000c;
  // Timing
  localparam longint CLK_HZ = 40000000;
  localparam longint POR_TIME_MS = 18;
  localparam longint POR_CYCLES = POR_TIME_MS * CLK_HZ / 1000;
  localparam int POR_EXTRA_CYCLES = 18;
  localparam longint WDOG_TIME_MS = 8;
  localparam longint WDOG_RC_CYCLES = WDOG_TIME_MS * CLK_HZ / 1000;
  localparam int WDOG_SYSCLK_CYCLES = 32512;
  localparam int RST_W = 21;
  localparam int WDOG_W = 20;

  typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_HALT, ST_STOP} sys_e;
  typedef enum logic [2:0] {IS_IDLE, IS_PUSH, IS_HI, IS_LO, IS_FIN} seq_e;

  typedef struct packed {
    logic wr;
    logic z;
    logic s;
    logic v;
  } flags_s;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } vector_s;
endpackage

// ### hdl/irq_sleep_watchdog_ctrl.sv
// Interrupt controller, halt/stop sequencing and watchdog with Wishbone registers
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// [RL1] Six requests: pin falls on analog two, threshold, analog one; analog two rise; two timers.
// [RL2] Vectors sit in bytes 0..11; request n fetches its 16-bit address from 2n, 2n+1.
// [RL3] Mask register enables all requests globally and each request individually.
// [RL4] Among pending enabled requests, a priority encoder steered by priority register picks.
// [RL5] Grant clears global enable, has core push PC and flags, then branches via vector.
// [RL6] Pending bits record edges even while masked, so software can poll them.
// [RL7] Halt stops the core clock only; oscillator, timers and pin requests stay live.
// [RL8] Halt ends only by a taken enabled interrupt; core resumes after halt.
// [RL9] Stop halts core clock and oscillator; power loss or low-voltage reset ends it.
// [RL10] Stop ends at once when stop-wake pin is low as stop executes.
// [RL11] Any stop release restarts fetching at address 000C hex.
// [RL12] Stop-wake release keeps port mode registers; no power-on defaults reload.
// [RL13] Software places a no-op FF hex right before stop or halt.
// [RL14] First refresh opcode enables watchdog; later ones clear its counter.
// [RL15] No instruction can stop an enabled watchdog; software must refresh each period.
// [RL16] Watchdog timeout gives a reset like power-on: power-on delay plus 18 cycles.
// [RL17] Refresh opcode sets zero flag, clears sign and overflow flags.
// [RL18] Without permanent option watchdog stops in stop mode, is off after any reset.
// [RL19] Halt-run opcode keeps watchdog counting in halt; otherwise halt stops it.
// [RL20] Halt-run opcode is ignored until the watchdog has been enabled.
// [RL21] Permanent option: enabled after reset, runs everywhere; refresh only; halt-run inert.
// [RL22] System clock option: timeout after 32512 clocks, and no counting in stop.
// [RL23] Granting a request clears its pending bit so one edge is serviced once.
module irq_sleep_watchdog_ctrl #(
  parameter longint POR_CYC = sysctl_pkg::POR_CYCLES,
  parameter longint WDOG_RC_CYC = sysctl_pkg::WDOG_RC_CYCLES,
  parameter bit PERMANENT_WDOG = 1'b0,
  parameter bit WDOG_ON_SYSCLK = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins, asynchronous
  input wire logic analog_one_pin,
  input wire logic analog_two_pin,
  input wire logic threshold_pin,
  input wire logic stop_wake_pin,
  // Timer events, same clock
  input wire logic counter_timer_zero,
  input wire logic counter_timer_one,
  // Core sequencer
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic halt_exec,
  input wire logic stop_exec,
  input wire logic cpu_boundary,
  input wire logic cpu_push_done,
  output logic irq_take,
  output sysctl_pkg::vector_s vector,
  output sysctl_pkg::flags_s flags,
  output logic restart,
  output logic [15:0] restart_pc,
  output logic core_reset,
  output logic cpu_clk_en,
  output logic osc_run,
  // Program memory read port, data one cycle after address
  output logic [3:0] pmem_addr,
  output logic pmem_rd,
  input wire logic [7:0] pmem_rdata
);
  import sysctl_pkg::*;

  localparam longint RST_LAST = POR_CYC + POR_EXTRA_CYCLES - 1;
  localparam longint WDOG_LIMIT = WDOG_ON_SYSCLK ? WDOG_SYSCLK_CYCLES : WDOG_RC_CYC;

  // Counters are sized in the package; refuse settings that they cannot hold
  if (POR_CYC < 1) begin : g_bad_por
    $error("Power-on delay must be at least one cycle");
  end
  if (RST_LAST >= (64'd1 << RST_W)) begin : g_bad_rst
    $error("Reset stretch does not fit its counter");
  end
  if (WDOG_LIMIT > (64'd1 << WDOG_W) || WDOG_LIMIT < 1) begin : g_bad_wdog
    $error("Watchdog period does not fit its counter");
  end
  // Vector bytes 2n and 2n+1 must stay inside the four-bit fetch address
  if (NUM_REQ != 6) begin : g_bad_req
    $error("Request logic is built for six sources");
  end

  typedef struct packed {
    sys_e sys;
    seq_e seq;
    logic [2:0] sel;
    logic [7:0] vec_hi;
    logic [5:0] pend;
    logic [7:0] mask;
    logic [2:0] prio;
    logic wdog_en;
    logic wdog_halt;
    logic [RST_W-1:0] rst_cnt;
    logic [WDOG_W-1:0] wdog_cnt;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [2:0] prev;
    logic ack;
    logic [7:0] rdata;
    vector_s vec;
    logic flag_wr;
    logic restart;
    logic [3:0] paddr;
    logic prd;
  } state_s;

  state_s q;
  state_s n;

  // Pins idle high, so the edge history starts high as well; a zero start
  // would report a rising edge on analog two as soon as reset lets go
  function automatic state_s reset_state();
    state_s r;
    r = '0;
    r.sys = ST_RESET;
    r.seq = IS_IDLE;
    r.mask = MASK_RST;
    r.pend = PEND_RST;
    r.prio = PRIO_RST;
    r.sync1 = '1;
    r.sync2 = '1;
    r.prev = '1;
    return r;
  endfunction

  localparam state_s RST_STATE = reset_state();

  // Rotating priority: start index from the priority register, ascending with wrap
  function automatic logic [3:0] pick(input logic [5:0] act, input logic [2:0] start);
    logic [3:0] idx;
    logic [3:0] base;
    pick = 4'h0;
    base = (start > 3'd5) ? 4'h0 : {1'b0, start};
    for (int k = NUM_REQ - 1; k >= 0; k--) begin
      idx = base + 4'(k);
      if (idx >= 4'(NUM_REQ)) begin
        idx = idx - 4'(NUM_REQ);
      end
      if (act[idx[2:0]]) begin
        pick = {1'b1, idx[2:0]};
      end
    end
  endfunction

  logic [3:0] pin_now;
  logic [5:0] req_set;
  logic [5:0] req_clr;
  logic [5:0] active;
  logic [3:0] win;
  logic bus_req;
  logic bus_wr;
  logic [7:0] bus_idx;
  logic wdog_runs;
  logic take;
  logic is_refresh;
  logic is_halt_run;
  logic [2:0] pin_fell;
  logic pin_rose_two;
  logic core_idle;

  assign pin_now = {stop_wake_pin, threshold_pin, analog_two_pin, analog_one_pin};
  assign bus_req = wb_cyc_i & wb_stb_i & ~q.ack;
  assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  assign bus_idx = wb_adr_i[9:2];
  assign is_refresh = op_valid & (op_code == OP_WDOG_REFRESH) & (q.sys == ST_RUN);
  assign is_halt_run = op_valid & (op_code == OP_WDOG_HALT_RUN) & (q.sys == ST_RUN);
  // Sleep strobes are ignored while a grant is being worked off
  assign core_idle = (q.sys == ST_RUN) & (q.seq == IS_IDLE);

  // Only the second sync stage and its history feed the edge detectors
  for (genvar i = 0; i < 3; i++) begin : g_edge
    assign pin_fell[i] = q.prev[i] & ~q.sync2[i];
  end
  assign pin_rose_two = ~q.prev[1] & q.sync2[1];

  always_comb begin
    // Edges come from the second sync stage against its own history
    req_set[0] = pin_fell[1]; // RL1
    req_set[1] = pin_fell[2]; // RL1
    req_set[2] = pin_fell[0]; // RL1
    req_set[3] = pin_rose_two; // RL1
    req_set[4] = counter_timer_zero; // RL1
    req_set[5] = counter_timer_one; // RL1
  end

  assign active = q.pend & q.mask[5:0] & {NUM_REQ{q.mask[MASK_GLOBAL_BIT]}}; // RL3
  assign win = pick(active, q.prio); // RL4
  // Halt leaves through the same grant; the core clock comes back for the push
  assign take = win[3] & (q.seq == IS_IDLE)
    & (((q.sys == ST_RUN) & cpu_boundary) | (q.sys == ST_HALT)); // RL8

  always_comb begin
    unique case (q.sys)
      ST_RUN: wdog_runs = q.wdog_en;
      ST_HALT: wdog_runs = q.wdog_en & (q.wdog_halt | PERMANENT_WDOG); // RL19
      ST_STOP: wdog_runs = q.wdog_en & PERMANENT_WDOG & ~WDOG_ON_SYSCLK; // RL18 RL22
      ST_RESET: wdog_runs = 1'b0; // RL18
    endcase
  end

  always_comb begin
    n = q;
    n.sync1 = pin_now;
    n.sync2 = q.sync1;
    n.prev = q.sync2[2:0];
    n.flag_wr = 1'b0;
    n.restart = 1'b0;
    n.prd = 1'b0;
    n.vec.valid = 1'b0;
    req_clr = 6'h00;

    // Bus: one wait state, ack drops the cycle after it rises
    n.ack = bus_req;
    n.rdata = 8'h00;
    if (bus_req & ~wb_we_i) begin
      unique case (bus_idx)
        IDX_PEND: n.rdata = {2'b00, q.pend}; // RL6
        IDX_MASK: n.rdata = q.mask;
        IDX_STAT: n.rdata = {q.seq, q.sys, q.wdog_halt, q.wdog_en, 1'b0};
        default: n.rdata = 8'h00;
      endcase
    end
    if (bus_wr) begin
      unique case (bus_idx)
        IDX_PRIO: n.prio = wb_dat_i[2:0];
        IDX_MASK: n.mask = wb_dat_i[7:0]; // RL3
        IDX_PEND: n.pend = wb_dat_i[5:0];
        default: n.mask = n.mask;
      endcase
    end

    // Interrupt sequence: grant, push, two vector bytes, branch
    unique case (q.seq)
      IS_IDLE: begin
        if (take) begin
          n.seq = IS_PUSH;
          n.sel = win[2:0];
          req_clr[win[2:0]] = 1'b1; // RL23
          n.mask[MASK_GLOBAL_BIT] = 1'b0; // RL5
          if (q.sys == ST_HALT) begin
            n.sys = ST_RUN; // RL8
          end
        end
      end
      IS_PUSH: begin
        if (cpu_push_done) begin
          n.seq = IS_HI;
          n.paddr = {q.sel, 1'b0}; // RL2
          n.prd = 1'b1;
        end
      end
      IS_HI: begin
        n.seq = IS_LO;
        n.paddr = q.paddr + 4'h1; // RL2
        n.prd = 1'b1;
      end
      IS_LO: begin
        n.seq = IS_FIN;
        n.vec_hi = pmem_rdata;
      end
      IS_FIN: begin
        n.seq = IS_IDLE;
        n.vec.addr = {q.vec_hi, pmem_rdata}; // RL2 RL5
        n.vec.valid = 1'b1;
      end
    endcase

    // Set wins over clear, whether the clear comes from the bus or a grant
    n.pend = (n.pend & ~req_clr) | req_set; // RL6

    // Watchdog opcodes
    if (is_refresh) begin
      n.flag_wr = 1'b1; // RL17
      n.wdog_en = 1'b1; // RL14 RL21
      n.wdog_cnt = '0; // RL14
    end
    if (is_halt_run & q.wdog_en & ~PERMANENT_WDOG) begin
      n.wdog_halt = 1'b1; // RL19 RL20 RL21
    end

    // Sleep entry
    // The wake pin is read two cycles late; software sets it well before the stop
    if (core_idle) begin
      if (halt_exec) begin
        n.sys = ST_HALT; // RL7
      end else if (stop_exec) begin
        if (~q.sync2[3]) begin
          // Port modes are left alone on this path
          n.restart = 1'b1; // RL10 RL11 RL12
        end else begin
          n.sys = ST_STOP; // RL9
        end
      end
    end

    // Watchdog count; only reset can disable it once enabled
    if (wdog_runs & ~is_refresh) begin // RL15
      if (q.wdog_cnt == WDOG_W'(WDOG_LIMIT - 1)) begin
        n.sys = ST_RESET; // RL16
        n.rst_cnt = '0;
        n.seq = IS_IDLE;
        n.wdog_en = 1'b0; // RL18
        n.wdog_halt = 1'b0;
        n.wdog_cnt = '0;
        n.pend = PEND_RST;
        n.mask = MASK_RST;
        n.prio = PRIO_RST;
      end else begin
        n.wdog_cnt = q.wdog_cnt + 1'b1;
      end
    end

    // Reset stretch, then restart at the fixed fetch address
    if (q.sys == ST_RESET) begin
      if (q.rst_cnt == RST_W'(RST_LAST)) begin
        n.sys = ST_RUN;
        n.restart = 1'b1; // RL11 RL16
        n.wdog_en = PERMANENT_WDOG; // RL18 RL21
        n.wdog_cnt = '0;
      end else begin
        n.rst_cnt = q.rst_cnt + 1'b1;
      end
    end
  end

  // Power loss or a low-voltage trip arrives here; the stretch then runs from zero
  always_ff @(posedge mclk or negedge rst_n) begin // RL9
    if (!rst_n) begin
      q <= RST_STATE;
    end else begin
      q <= n;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = {24'h000000, q.rdata};
  assign irq_take = (q.seq == IS_PUSH); // RL5
  assign vector = q.vec;
  assign flags = '{wr: q.flag_wr, z: 1'b1, s: 1'b0, v: 1'b0}; // RL17
  assign restart = q.restart;
  assign restart_pc = RESTART_PC; // RL11
  assign core_reset = (q.sys == ST_RESET); // RL16
  assign cpu_clk_en = (q.sys == ST_RUN); // RL7 RL9
  assign osc_run = (q.sys != ST_STOP); // RL7 RL9
  assign pmem_addr = q.paddr;
  assign pmem_rd = q.prd;
endmodule

`default_nettype wire

// ### testbench/core_model.sv
// Core sequencer and program memory seen from the block
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input wire logic mclk,
  input wire logic [3:0] push_wait,
  input wire logic irq_take,
  input wire logic [3:0] pmem_addr,
  input wire logic pmem_rd,
  output logic cpu_push_done,
  output logic [7:0] pmem_rdata
);
  logic [3:0] wait_q = '0;
  always @(posedge mclk) begin
    // Push takes push_wait+1 cycles before done, one done pulse per grant
    wait_q <= (irq_take && !cpu_push_done) ? wait_q + 4'h1 : 4'h0;
    cpu_push_done <= irq_take && !cpu_push_done && wait_q == push_wait;
    // Byte k holds 10h+k; idle cycles show inverted data so stale bytes never match
    pmem_rdata <= pmem_rd ? 8'h10 + {4'h0, pmem_addr} : ~pmem_rdata;
  end
endmodule
`default_nettype wire

// ### testbench/irq_sleep_watchdog_ctrl_props.sv
// Checker for grant, vector fetch, sleep and refresh behaviour
`timescale 1ns/100ps
`default_nettype none
module irq_sleep_watchdog_ctrl_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic stop_wake_pin,
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic halt_exec,
  input wire logic stop_exec,
  input wire logic cpu_push_done,
  input wire logic irq_take,
  input wire sysctl_pkg::vector_s vector,
  input wire sysctl_pkg::flags_s flags,
  input wire logic restart,
  input wire logic [15:0] restart_pc,
  input wire logic core_reset,
  input wire logic cpu_clk_en,
  input wire logic osc_run,
  input wire logic [3:0] pmem_addr,
  input wire logic pmem_rd
);
  import sysctl_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence rd_pair;
    pmem_rd && !pmem_addr[0] ##1 pmem_rd && pmem_addr == $past(pmem_addr) + 4'h1;
  endsequence
  // Core request taken only in run, outside reset, while no grant is in its push stage
  sequence issued(logic e);
    e && cpu_clk_en && !irq_take && !core_reset;
  endsequence
  a_vec_fetch: assert property ($rose(pmem_rd) |-> rd_pair ##[2:3] vector.valid)
    else $error("vector fetch out of order");
  a_push_then_read: assert property (irq_take && cpu_push_done |=> !irq_take && pmem_rd)
    else $error("no vector read after push");
  a_take_holds: assert property (irq_take && !cpu_push_done |=> irq_take)
    else $error("grant dropped before push");
  a_halt_sleep: assert property (issued(halt_exec) |=> !cpu_clk_en && osc_run)
    else $error("halt entry wrong");
  a_stop_sleep: assert property (issued(stop_exec && $past(stop_wake_pin) && $past(stop_wake_pin, 2)
    && $past(stop_wake_pin, 3)) |=> !osc_run && !cpu_clk_en)
    else $error("stop entry wrong");
  a_wake_restart: assert property (issued(stop_exec && !$past(stop_wake_pin) && !$past(stop_wake_pin, 2)
    && !$past(stop_wake_pin, 3)) |=> restart && !core_reset && restart_pc == RESTART_PC)
    else $error("stop wake release wrong");
  a_refresh_flags: assert property (issued(op_valid && op_code == OP_WDOG_REFRESH)
    |=> flags.wr && flags.z && !flags.s && !flags.v)
    else $error("refresh flags wrong");
  a_halt_exit: assert property (!cpu_clk_en && osc_run && !core_reset && !irq_take && !restart
    |=> !cpu_clk_en || irq_take)
    else $error("halt left without interrupt");
endmodule
bind irq_sleep_watchdog_ctrl irq_sleep_watchdog_ctrl_chk chk (.mclk, .rst_n, .stop_wake_pin, .op_valid,
  .op_code, .halt_exec, .stop_exec, .cpu_push_done, .irq_take, .vector, .flags, .restart, .restart_pc,
  .core_reset, .cpu_clk_en, .osc_run, .pmem_addr, .pmem_rd);
`default_nettype wire

// ### testbench/testbench.sv
// Bench: registers, interrupts, sleep modes and watchdog
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sysctl_pkg::*;
  logic mclk = '0, rst_n = '0, cyc = '0, stb = '0, we = '0, sw = '1, a1 = '1, a2 = '1, th = '1;
  logic pd, ack, take, rs, crst, cen, osc, prd;
  logic [4:0] stv = '0;
  logic [3:0] sel = 4'hf, pw = 4'h0, pa;
  logic [7:0] opc = 8'h00, pr, rd;
  logic [9:0] adr = '0;
  logic [31:0] wd = '0, dato;
  logic [15:0] rpc;
  vector_s vec;
  flags_s fl;
  int mismatches = 0, cmp_count = 0;
  irq_sleep_watchdog_ctrl #(.POR_CYC(20), .WDOG_RC_CYC(50)) dut (.mclk, .rst_n, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dato),
    .wb_ack_o(ack), .analog_one_pin(a1), .analog_two_pin(a2), .threshold_pin(th), .stop_wake_pin(sw),
    .counter_timer_zero(stv[2]), .counter_timer_one(stv[3]), .op_valid(stv[4]), .op_code(opc),
    .halt_exec(stv[0]), .stop_exec(stv[1]), .cpu_boundary(1'b1), .cpu_push_done(pd), .irq_take(take),
    .vector(vec), .flags(fl), .restart(rs), .restart_pc(rpc), .core_reset(crst), .cpu_clk_en(cen),
    .osc_run(osc), .pmem_addr(pa), .pmem_rd(prd), .pmem_rdata(pr));
  core_model cm (.mclk, .push_wait(pw), .irq_take(take), .pmem_addr(pa), .pmem_rd(prd),
    .cpu_push_done(pd), .pmem_rdata(pr));
  initial forever #12.5 mclk = ~mclk;
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc_n(int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wt(ref logic s, input int n);
    for (int k = 0; k < n && s !== 1'b1; k++) @(posedge mclk);
  endtask
  task automatic wb(logic w, logic [7:0] i, logic [7:0] d);
    {cyc, stb, we, adr, wd} <= {2'b11, w, i, 2'b00, 24'h0, d};
    @(posedge mclk);
    wt(ack, 20);
    rd = dato[7:0];
    chk("ack", ack, 1);
    {cyc, stb} <= 2'b00;
    @(posedge mclk);
  endtask
  task automatic st(logic [4:0] m, logic [7:0] c);
    {stv, opc} <= {m, c};
    @(posedge mclk);
    stv <= '0;
    @(posedge mclk);
  endtask
  // Reset stretch length and restart address, counted from the first stretch cycle
  task automatic stretch();
    int n = 0;
    for (int k = 0; k < 200 && rs !== 1'b1; k++) begin
      n += int'(crst === 1'b1);
      @(posedge mclk);
    end
    chk("stretch", n, 38);
    chk("pc", rpc, RESTART_PC);
  endtask
  task automatic svc(int n);
    wt(take, 20);
    for (int k = 0; k < 40 && vec.valid !== 1'b1; k++) @(posedge mclk);
    chk("vector", vec.addr, {8'h10 + 8'(2 * n), 8'h11 + 8'(2 * n)});
    cyc_n(2);
  endtask
  task automatic t_regs();
    wb(0, IDX_MASK, 0);
    chk("mask", rd, MASK_RST);
    wb(0, IDX_PEND, 0);
    chk("pend", rd, PEND_RST);
    wb(0, IDX_PRIO, 0);
    chk("prio", rd, 0);
    wb(0, 8'h10, 0);
    chk("unmapped", rd, 0);
    wb(1, IDX_MASK, 8'h85);
    sel <= 4'he;
    wb(1, IDX_MASK, 8'h00);
    sel <= 4'hf;
    wb(0, IDX_MASK, 0);
    chk("mask", rd, 8'h85);
    wb(1, IDX_MASK, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_irq();
    for (int n = 0; n < 6; n++) begin
      case (n)
        0: a2 <= 1'b0;
        1: th <= 1'b0;
        2: a1 <= 1'b0;
        3: a2 <= 1'b1;
        default: stv <= 5'(1 << (n - 2));
      endcase
      @(posedge mclk);
      stv <= '0;
      cyc_n(6);
      wb(0, IDX_PEND, 0);
      chk("pend", rd, 1 << n);
      wb(1, IDX_MASK, 8'(1 << n));
      cyc_n(8);
      chk("take", take, 0);
      wb(1, IDX_MASK, 8'h80 | 8'(1 << n));
      svc(n);
      wb(0, IDX_MASK, 0);
      chk("mask", rd, 1 << n);
      wb(0, IDX_PEND, 0);
      chk("pend", rd, 0);
    end
    $display("test irq done");
  endtask
  task automatic t_prio();
    wb(1, IDX_PRIO, 8'h05);
    st(5'h0c, 8'h00);
    pw <= 4'h6;
    wb(1, IDX_MASK, 8'hb0);
    svc(5);
    wb(1, IDX_MASK, 8'hb0);
    svc(4);
    pw <= 4'h0;
    $display("test prio done");
  endtask
  task automatic t_halt();
    st(5'h10, OP_WDOG_REFRESH);
    st(5'h01, 8'h00);
    cyc_n(100);
    chk("clk", cen, 0);
    chk("osc", osc, 1);
    chk("crst", crst, 0);
    wb(1, IDX_MASK, 8'h90);
    st(5'h04, 8'h00);
    svc(4);
    st(5'h10, OP_WDOG_REFRESH);
    st(5'h10, OP_WDOG_HALT_RUN);
    st(5'h01, 8'h00);
    wt(crst, 70);
    chk("crst", crst, 1);
    stretch();
    $display("test halt done");
  endtask
  task automatic t_wdog();
    st(5'h10, OP_WDOG_HALT_RUN);
    wb(0, IDX_STAT, 0);
    chk("stat", rd & 8'h06, 0);
    st(5'h10, OP_WDOG_REFRESH);
    wb(0, IDX_STAT, 0);
    chk("stat", rd & 8'h06, 8'h02);
    repeat (4) begin
      cyc_n(30);
      st(5'h10, OP_WDOG_REFRESH);
    end
    chk("crst", crst, 0);
    wt(crst, 60);
    stretch();
    wb(0, IDX_STAT, 0);
    chk("stat", rd & 8'h02, 0);
    $display("test wdog done");
  endtask
  task automatic t_stop();
    wb(1, IDX_MASK, 8'h05);
    st(5'h10, OP_WDOG_REFRESH);
    sw <= 1'b0;
    cyc_n(4);
    st(5'h02, 8'h00);
    chk("restart", rs, 1);
    chk("crst", crst, 0);
    wb(0, IDX_MASK, 0);
    chk("mask", rd, 8'h05);
    sw <= 1'b1;
    cyc_n(4);
    st(5'h02, 8'h00);
    cyc_n(100);
    chk("osc", osc, 0);
    chk("crst", crst, 0);
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    stretch();
    $display("test stop done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    cyc_n(5000);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    cyc_n(10);
    rst_n <= 1'b1;
    @(posedge mclk);
    stretch();
    t_regs();
    t_irq();
    t_prio();
    t_halt();
    t_wdog();
    t_stop();
    tally_and_finish();
  end
endmodule
`default_nettype wire
